// File: logic/interworking_pkg.sv
// Purpose: Shared constants and types for the packet/circuit interworking unit.
// Assumes: Octet-wide data streams, one octet per cycle when valid.
// Notes:   Times are given in microseconds and turned into cycles of CORE_CLK.
package interworking_pkg;
    localparam int          CLK_MHZ          = 50;
    localparam int          GUARD_US         = 100;
    localparam int          GUARD_CYCLES     = GUARD_US * CLK_MHZ;
    localparam int          RETRY_US         = 1000;
    localparam int          RETRY_CYCLES     = RETRY_US * CLK_MHZ;
    localparam logic [3:0]  RETRY_LIMIT      = 4'h3;
    localparam logic [11:0] MAX_BLOCK        = 12'h7FF;
    localparam logic [11:0] DEFAULT_PKT_SIZE = 12'h080;
    localparam logic        RESET_QBIT_MODE  = 1'b0;

    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_SETUP  = 9'h002,
        ST_DATA   = 9'h004,
        ST_DISC   = 9'h008,
        ST_CLRSIG = 9'h010,
        ST_CLRPKT = 9'h020,
        ST_GUARD  = 9'h040,
        ST_REJECT = 9'h080,
        ST_RELINK = 9'h100
    } ctl_state_type;

    typedef enum logic [2:0] {
        WHY_NONE    = 3'h0,
        WHY_RESET   = 3'h1,
        WHY_RESTART = 3'h2,
        WHY_PKTCLR  = 3'h3,
        WHY_CKTCLR  = 3'h4,
        WHY_LOCAL   = 3'h5,
        WHY_NOANS   = 3'h6
    } cause_type;
endpackage

// File: logic/packet_circuit_interworking.sv
// Purpose: Interworking unit between a packet switched network and a circuit switched network.
// Assumes: Both sides are logic on CORE_CLK; frame and packet events arrive as one-cycle pulses.
// Notes:   Call set-up mapping and unit-initiated restart are handled elsewhere.
`timescale 1ns/10ps
module packet_circuit_interworking
    import interworking_pkg::*;
#(
    parameter int GUARD_COUNT = GUARD_CYCLES,
    parameter int RETRY_COUNT = RETRY_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    input  wire logic        QBIT_ZERO_MODE,
    input  wire logic        DISC_BEFORE_CLEAR,
    input  wire logic [11:0] PKT_SIZE,
    input  wire logic        LINE_FREE,
    input  wire logic        PKT_CALL_REQ,
    input  wire logic        PKT_CLEAR_REQ,
    input  wire logic        PKT_CLEAR_CONF,
    input  wire logic        PKT_RESET_REQ,
    input  wire logic        PKT_RESTART_REQ,
    input  wire logic        CKT_CONNECTED,
    input  wire logic        CKT_UA,
    input  wire logic        CKT_DM,
    input  wire logic        CKT_CLEAR_IND,
    input  wire logic        CKT_CLEAR_CONF,
    input  wire logic        LOCAL_RELEASE,
    input  wire logic        PIN_VALID,
    input  wire logic [7:0]  PIN_DATA,
    input  wire logic        PIN_LAST,
    input  wire logic        PIN_QBIT,
    input  wire logic        PIN_DBIT,
    input  wire logic        PIN_MBIT,
    input  wire logic        CIN_VALID,
    input  wire logic [7:0]  CIN_DATA,
    input  wire logic        CIN_LAST,
    input  wire logic        CIN_QBIT,
    output logic             COUT_VALID,
    output logic [7:0]       COUT_DATA,
    output logic             COUT_LAST,
    output logic             COUT_QBIT,
    output logic             COUT_MBIT,
    output logic             POUT_VALID,
    output logic [7:0]       POUT_DATA,
    output logic             POUT_LAST,
    output logic             POUT_QBIT,
    output logic             POUT_DBIT,
    output logic             POUT_MBIT,
    output logic             CKT_SABM,
    output logic             CKT_DISC,
    output logic             CKT_CLEAR_SIG,
    output logic             PKT_CLEAR_REQ_OUT,
    output logic             PKT_CLEAR_CONF_OUT,
    output logic             PKT_RESET_CONF,
    output logic             PKT_RESTART_CONF,
    output logic             READY_FOR_CALLS,
    output logic             BLOCK_TOO_LONG
);
    localparam logic [11:0] SEG_ONE = 12'h001;

    ctl_state_type state_q;
    ctl_state_type state_d;
    cause_type     cause_q;
    logic [31:0]   timer_q;
    logic [3:0]    retry_q;
    logic          clr_conf_seen_q;
    logic          ckt_clear_done_q;
    logic [11:0]   seg_cnt_q;
    logic [11:0]   blk_cnt_q;
    logic          data_on;
    logic          seg_end;

    assign data_on = (state_q == ST_DATA);
    assign seg_end = (seg_cnt_q + SEG_ONE >= PKT_SIZE);

    // Packet side to circuit side: one packet becomes one block
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            COUT_VALID <= 1'b0;
            COUT_DATA  <= 8'h00;
            COUT_LAST  <= 1'b0;
            COUT_QBIT  <= 1'b0;
            COUT_MBIT  <= 1'b0;
        end else begin
            COUT_VALID <= PIN_VALID && data_on;
            COUT_DATA  <= PIN_DATA;
            COUT_LAST  <= PIN_LAST;
            COUT_MBIT  <= PIN_MBIT;
            COUT_QBIT  <= QBIT_ZERO_MODE ? 1'b0 : PIN_QBIT;
        end
    end

    // PIN_DBIT has no reader: the delivery-confirmation request is dropped
    logic unused_dbit;
    assign unused_dbit = PIN_DBIT;

    // Circuit side to packet side with segmentation at the negotiated size
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            POUT_VALID     <= 1'b0;
            POUT_DATA      <= 8'h00;
            POUT_LAST      <= 1'b0;
            POUT_QBIT      <= 1'b0;
            POUT_DBIT      <= 1'b0;
            POUT_MBIT      <= 1'b0;
            seg_cnt_q      <= 12'h000;
            blk_cnt_q      <= 12'h000;
            BLOCK_TOO_LONG <= 1'b0;
        end else begin
            POUT_VALID <= CIN_VALID && data_on;
            POUT_DATA  <= CIN_DATA;
            POUT_DBIT  <= 1'b0;
            POUT_QBIT  <= QBIT_ZERO_MODE ? 1'b0 : CIN_QBIT;
            if (CIN_VALID && data_on) begin
                // Packet ends at block end or when segment is full
                POUT_LAST <= CIN_LAST || seg_end;
                POUT_MBIT <= !CIN_LAST;
                if (CIN_LAST || seg_end) begin
                    seg_cnt_q <= 12'h000;
                end else begin
                    seg_cnt_q <= seg_cnt_q + SEG_ONE;
                end
                if (CIN_LAST) begin
                    blk_cnt_q <= 12'h000;
                end else if (blk_cnt_q != MAX_BLOCK) begin
                    blk_cnt_q <= blk_cnt_q + SEG_ONE;
                end
                // Flags blocks past 2048 octets; data still passes
                BLOCK_TOO_LONG <= (blk_cnt_q == MAX_BLOCK) && !CIN_LAST;
            end else begin
                POUT_LAST      <= 1'b0;
                POUT_MBIT      <= 1'b0;
                BLOCK_TOO_LONG <= 1'b0;
            end
        end
    end

    // Connection control
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (PKT_RESTART_REQ) begin
                    state_d = ST_GUARD;
                end else if (PKT_CALL_REQ) begin
                    state_d = LINE_FREE ? ST_SETUP : ST_REJECT;
                end
            end
            ST_SETUP: begin
                if (PKT_RESTART_REQ) begin
                    state_d = ST_DISC;
                end else if (PKT_CLEAR_REQ) begin
                    state_d = ST_CLRSIG;
                end else if (CKT_UA) begin
                    state_d = ST_DATA;
                end else if (timer_q == 32'h0 && retry_q == RETRY_LIMIT) begin
                    state_d = ST_CLRSIG;
                end
            end
            ST_DATA: begin
                if (PKT_RESTART_REQ || PKT_RESET_REQ) begin
                    state_d = ST_DISC;
                end else if (PKT_CLEAR_REQ || LOCAL_RELEASE) begin
                    state_d = DISC_BEFORE_CLEAR ? ST_DISC : ST_CLRSIG;
                end else if (CKT_CLEAR_IND) begin
                    state_d = ST_CLRSIG;
                end
            end
            ST_DISC: begin
                if (CKT_UA || CKT_DM || timer_q == 32'h0) begin
                    state_d = (cause_q == WHY_RESET) ? ST_RELINK : ST_CLRSIG;
                end
            end
            ST_RELINK: begin
                if (CKT_UA) begin
                    state_d = ST_DATA;
                end else if (timer_q == 32'h0 && retry_q == RETRY_LIMIT) begin
                    state_d = ST_CLRSIG;
                end
            end
            ST_CLRSIG: begin
                if (ckt_clear_done_q || CKT_CLEAR_CONF) begin
                    state_d = ST_CLRPKT;
                end
            end
            ST_CLRPKT: begin
                if (cause_q == WHY_RESTART || cause_q == WHY_PKTCLR || clr_conf_seen_q || PKT_CLEAR_CONF) begin
                    state_d = ST_GUARD;
                end
            end
            ST_GUARD: begin
                if (timer_q == 32'h0) begin
                    state_d = ST_IDLE;
                end
            end
            ST_REJECT: begin
                if (PKT_CLEAR_CONF) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cause of the current release, kept until idle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cause_q <= WHY_NONE;
        end else if (state_d == ST_IDLE) begin
            cause_q <= WHY_NONE;
        end else if (state_q != ST_DISC && state_q != ST_CLRSIG && state_q != ST_CLRPKT && state_q != ST_GUARD) begin
            if (PKT_RESTART_REQ) begin
                cause_q <= WHY_RESTART;
            end else if (state_q == ST_DATA && PKT_RESET_REQ) begin
                cause_q <= WHY_RESET;
            end else if (PKT_CLEAR_REQ) begin
                cause_q <= WHY_PKTCLR;
            end else if (state_q == ST_DATA && LOCAL_RELEASE) begin
                cause_q <= WHY_LOCAL;
            end else if (state_q == ST_DATA && CKT_CLEAR_IND) begin
                cause_q <= WHY_CKTCLR;
            end else if (state_d == ST_CLRSIG) begin
                cause_q <= WHY_NOANS;
            end
        end
    end

    // Shared timer: retry period in set-up and disconnect, guard delay after clearing
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_q <= 32'h0;
            retry_q <= 4'h0;
        end else if (state_d != state_q) begin
            timer_q <= (state_d == ST_GUARD) ? GUARD_COUNT[31:0] - 32'h1 : RETRY_COUNT[31:0] - 32'h1;
            retry_q <= 4'h0;
        end else if (timer_q == 32'h0) begin
            timer_q <= RETRY_COUNT[31:0] - 32'h1;
            retry_q <= retry_q + 4'h1;
        end else begin
            timer_q <= timer_q - 32'h1;
        end
    end

    // Sticky completion flags; a set in the clearing cycle wins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            clr_conf_seen_q  <= 1'b0;
            ckt_clear_done_q <= 1'b0;
        end else begin
            if (PKT_CLEAR_CONF) begin
                clr_conf_seen_q <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                clr_conf_seen_q <= 1'b0;
            end
            if (CKT_CLEAR_CONF) begin
                ckt_clear_done_q <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                ckt_clear_done_q <= 1'b0;
            end
        end
    end

    // Control pulses toward both networks
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CKT_SABM           <= 1'b0;
            CKT_DISC           <= 1'b0;
            CKT_CLEAR_SIG      <= 1'b0;
            PKT_CLEAR_REQ_OUT  <= 1'b0;
            PKT_CLEAR_CONF_OUT <= 1'b0;
            PKT_RESET_CONF     <= 1'b0;
            PKT_RESTART_CONF   <= 1'b0;
            READY_FOR_CALLS    <= 1'b0;
        end else begin
            // SABM on entry to relink, and on each retry expiry in set-up or relink while CKT_CONNECTED and retry_q differs from RETRY_LIMIT
            CKT_SABM <= ((state_q == ST_SETUP || state_q == ST_RELINK) && CKT_CONNECTED && timer_q == 32'h0
                         && retry_q != RETRY_LIMIT)
                        || (state_d == ST_RELINK && state_q != ST_RELINK);
            CKT_DISC      <= state_d == ST_DISC && state_q != ST_DISC;
            CKT_CLEAR_SIG <= state_d == ST_CLRSIG && state_q != ST_CLRSIG;
            // Clear request toward packet side unless it started the release
            PKT_CLEAR_REQ_OUT <= (state_d == ST_REJECT && state_q != ST_REJECT)
                                 || (state_d == ST_CLRSIG && state_q != ST_CLRSIG
                                     && cause_q != WHY_PKTCLR && cause_q != WHY_RESTART
                                     && !PKT_CLEAR_REQ && !PKT_RESTART_REQ);
            PKT_CLEAR_CONF_OUT <= state_q == ST_CLRPKT && state_d == ST_GUARD
                                  && cause_q == WHY_PKTCLR;
            PKT_RESET_CONF     <= state_q == ST_RELINK && state_d == ST_DATA;
            PKT_RESTART_CONF   <= state_q == ST_CLRPKT && state_d == ST_GUARD
                                  && cause_q == WHY_RESTART;
            READY_FOR_CALLS    <= state_d == ST_IDLE;
        end
    end
endmodule

// File: verification/packet_circuit_interworking_checker.sv
// Purpose: Port-level assertions for the interworking unit.
// Assumes: Single CORE_CLK domain, RST_B active low.
// Notes:   Timing follows the one-cycle registered outputs of the unit.
`timescale 1ns/10ps
module packet_circuit_interworking_checker (
    input wire logic       CORE_CLK,
    input wire logic       RST_B,
    input wire logic       QBIT_ZERO_MODE,
    input wire logic       LINE_FREE,
    input wire logic       PKT_CALL_REQ,
    input wire logic       READY_FOR_CALLS,
    input wire logic       CKT_UA,
    input wire logic       PIN_VALID,
    input wire logic [7:0] PIN_DATA,
    input wire logic       PIN_MBIT,
    input wire logic       CIN_QBIT,
    input wire logic       CIN_LAST,
    input wire logic       COUT_VALID,
    input wire logic [7:0] COUT_DATA,
    input wire logic       COUT_MBIT,
    input wire logic       POUT_VALID,
    input wire logic       POUT_LAST,
    input wire logic       POUT_QBIT,
    input wire logic       POUT_DBIT,
    input wire logic       POUT_MBIT,
    input wire logic       PKT_RESET_CONF,
    input wire logic       PKT_CLEAR_REQ_OUT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    property p_data_copy;
        COUT_VALID |-> $past(PIN_VALID) && COUT_DATA == $past(PIN_DATA);
    endproperty
    a_data_copy: assert property (p_data_copy) else $error("circuit octet differs");
    property p_q_zero;
        POUT_VALID && $past(QBIT_ZERO_MODE) |-> !POUT_QBIT;
    endproperty
    a_q_zero: assert property (p_q_zero) else $error("qualifier not forced low");
    property p_q_copy;
        POUT_VALID && !$past(QBIT_ZERO_MODE) |-> POUT_QBIT == $past(CIN_QBIT);
    endproperty
    a_q_copy: assert property (p_q_copy) else $error("qualifier not copied");
    property p_d_low;
        POUT_VALID |-> !POUT_DBIT;
    endproperty
    a_d_low: assert property (p_d_low) else $error("confirmation bit set");
    property p_m_seg;
        POUT_VALID |-> POUT_MBIT == !$past(CIN_LAST);
    endproperty
    a_m_seg: assert property (p_m_seg) else $error("more-data bit wrong");
    property p_m_keep;
        COUT_VALID |-> COUT_MBIT == $past(PIN_MBIT);
    endproperty
    a_m_keep: assert property (p_m_keep) else $error("more-data bit changed");
    property p_reset_conf;
        PKT_RESET_CONF |-> $past(CKT_UA);
    endproperty
    a_reset_conf: assert property (p_reset_conf) else $error("reset confirmed early");
    property p_no_line;
        READY_FOR_CALLS && PKT_CALL_REQ && !LINE_FREE |-> ##[1:3] PKT_CLEAR_REQ_OUT;
    endproperty
    a_no_line: assert property (p_no_line) else $error("no clear on busy lines");
    c_reset: cover property (PKT_RESET_CONF);
    c_clear: cover property (PKT_CLEAR_REQ_OUT);
    c_seg_end: cover property (POUT_VALID && POUT_LAST && !POUT_MBIT);
endmodule
bind packet_circuit_interworking packet_circuit_interworking_checker checker_i (.CORE_CLK, .RST_B,
    .QBIT_ZERO_MODE, .LINE_FREE, .PKT_CALL_REQ, .READY_FOR_CALLS, .CKT_UA, .PIN_VALID, .PIN_DATA,
    .PIN_MBIT, .CIN_QBIT, .CIN_LAST, .COUT_VALID, .COUT_DATA, .COUT_MBIT, .POUT_VALID, .POUT_LAST,
    .POUT_QBIT, .POUT_DBIT, .POUT_MBIT, .PKT_RESET_CONF, .PKT_CLEAR_REQ_OUT);

// File: verification/circuit_side_model.sv
// Purpose: Circuit-side exchange answering link and clearing events.
// Assumes: Answers come three cycles after each request pulse.
// Notes:   ANSWER_SABM low leaves link set-up unanswered.
`timescale 1ns/10ps
module circuit_side_model (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CKT_SABM,
    input wire logic CKT_DISC,
    input wire logic CKT_CLEAR_SIG,
    input wire logic ANSWER_SABM,
    output logic     CKT_UA,
    output logic     CKT_DM,
    output logic     CKT_CLEAR_CONF
);
    logic [2:0] sabm_q, disc_q, clr_q;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            {sabm_q, disc_q, clr_q} <= '0;
        end else begin
            sabm_q <= {sabm_q[1:0], CKT_SABM & ANSWER_SABM};
            disc_q <= {disc_q[1:0], CKT_DISC};
            clr_q <= {clr_q[1:0], CKT_CLEAR_SIG};
        end
    end
    assign CKT_UA = sabm_q[2] | disc_q[2];
    assign CKT_DM = 1'b0;
    assign CKT_CLEAR_CONF = clr_q[2];
endmodule

// File: verification/packet_circuit_interworking_tb_top.sv
// Purpose: Self-checking bench for the interworking unit.
// Assumes: Short guard and retry counts keep the run brief.
// Notes:   Packet-side events, CKT_CONNECTED and CKT_CLEAR_IND are driven here, circuit-side answers by the model.
`timescale 1ns/10ps
module packet_circuit_interworking_tb_top;
    import interworking_pkg::*;
    localparam int G = 8;
    logic CORE_CLK = 0, RST_B = 0, QBIT_ZERO_MODE = 0, DISC_BEFORE_CLEAR = 0, LINE_FREE = 0;
    logic PKT_CALL_REQ = 0, PKT_CLEAR_REQ = 0, PKT_CLEAR_CONF = 0, PKT_RESET_REQ = 0;
    logic PKT_RESTART_REQ = 0, CKT_CONNECTED = 0, LOCAL_RELEASE = 0, ans = 1;
    logic PIN_VALID = 0, PIN_LAST = 0, PIN_QBIT = 0, PIN_DBIT = 0, PIN_MBIT = 0;
    logic CIN_VALID = 0, CIN_LAST = 0, CIN_QBIT = 0;
    logic [11:0] PKT_SIZE = 12'h004;
    logic [7:0] PIN_DATA = 8'h00, CIN_DATA = 8'h00, COUT_DATA, POUT_DATA;
    logic CKT_UA, CKT_DM, CKT_CLEAR_IND = 0, CKT_CLEAR_CONF, COUT_VALID, COUT_LAST, COUT_QBIT;
    logic COUT_MBIT, POUT_VALID, POUT_LAST, POUT_QBIT, POUT_DBIT, POUT_MBIT, CKT_SABM, CKT_DISC;
    logic CKT_CLEAR_SIG, PKT_CLEAR_REQ_OUT, PKT_CLEAR_CONF_OUT, PKT_RESET_CONF, PKT_RESTART_CONF;
    logic READY_FOR_CALLS, BLOCK_TOO_LONG;
    int failures = 0, compares = 0, n, c0, c1, c2, c3;
    int cnt[8] = '{default: 0};
    logic [10:0] cq[$];
    logic [11:0] pq[$];
    packet_circuit_interworking #(.GUARD_COUNT(G), .RETRY_COUNT(16)) packet_circuit_interworking_i (
        .CORE_CLK, .RST_B, .QBIT_ZERO_MODE, .DISC_BEFORE_CLEAR, .PKT_SIZE, .LINE_FREE, .PKT_CALL_REQ,
        .PKT_CLEAR_REQ, .PKT_CLEAR_CONF, .PKT_RESET_REQ, .PKT_RESTART_REQ, .CKT_CONNECTED, .CKT_UA,
        .CKT_DM, .CKT_CLEAR_IND, .CKT_CLEAR_CONF, .LOCAL_RELEASE, .PIN_VALID, .PIN_DATA, .PIN_LAST,
        .PIN_QBIT, .PIN_DBIT, .PIN_MBIT, .CIN_VALID, .CIN_DATA, .CIN_LAST, .CIN_QBIT, .COUT_VALID,
        .COUT_DATA, .COUT_LAST, .COUT_QBIT, .COUT_MBIT, .POUT_VALID, .POUT_DATA, .POUT_LAST,
        .POUT_QBIT, .POUT_DBIT, .POUT_MBIT, .CKT_SABM, .CKT_DISC, .CKT_CLEAR_SIG, .PKT_CLEAR_REQ_OUT,
        .PKT_CLEAR_CONF_OUT, .PKT_RESET_CONF, .PKT_RESTART_CONF, .READY_FOR_CALLS, .BLOCK_TOO_LONG);
    circuit_side_model circuit_side_model_i (.CORE_CLK, .RST_B, .CKT_SABM, .CKT_DISC,
        .CKT_CLEAR_SIG, .ANSWER_SABM(ans), .CKT_UA, .CKT_DM, .CKT_CLEAR_CONF);
    initial begin
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    // Pulses are counted, so a scenario only compares counts before and after
    always @(posedge CORE_CLK) begin
        cnt[0] += CKT_SABM;
        cnt[1] += CKT_DISC;
        cnt[2] += CKT_CLEAR_SIG;
        cnt[3] += PKT_CLEAR_REQ_OUT;
        cnt[4] += PKT_CLEAR_CONF_OUT;
        cnt[5] += PKT_RESET_CONF;
        cnt[6] += PKT_RESTART_CONF;
        cnt[7] += BLOCK_TOO_LONG;
        if (COUT_VALID === 1'b1) cq.push_back({COUT_LAST, COUT_QBIT, COUT_MBIT, COUT_DATA});
        if (POUT_VALID === 1'b1) pq.push_back({POUT_LAST, POUT_MBIT, POUT_QBIT, POUT_DBIT, POUT_DATA});
    end
    task automatic tick();
        @(posedge CORE_CLK);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_cnt(int i, int m);
        for (int k = 0; k < 400 && cnt[i] < m; k++) tick();
        check(16'(cnt[i] >= m), 16'h0001);
    endtask
    task automatic wait_ready(output int m);
        for (m = 0; m < 400 && READY_FOR_CALLS !== 1'b1; m++) tick();
    endtask
    task automatic end_of_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_noline();
        c3 = cnt[3];
        pulse(PKT_CALL_REQ);
        wait_cnt(3, c3 + 1);
        repeat (3) tick();
        check(16'(READY_FOR_CALLS), 16'h0000);
        pulse(PKT_CLEAR_CONF);
        wait_ready(n);
        check(16'(n <= 3), 16'h0001);
    endtask
    task automatic t_connect();
        c0 = cnt[0];
        LINE_FREE = 1;
        CKT_CONNECTED = 1;
        pulse(PKT_CALL_REQ);
        wait_cnt(0, c0 + 1);
        repeat (8) tick();
    endtask
    task automatic t_data();
        QBIT_ZERO_MODE = 1;
        PIN_QBIT = 1;
        PIN_DBIT = 1;
        PIN_MBIT = 1;
        for (int i = 0; i < 3; i++) begin
            PIN_VALID = 1;
            PIN_DATA = 8'(8'hA0 + i);
            PIN_LAST = (i == 2);
            tick();
        end
        PIN_VALID = 0;
        QBIT_ZERO_MODE = 0;
        CIN_QBIT = 1;
        for (int i = 0; i < 10; i++) begin
            CIN_VALID = 1;
            CIN_DATA = 8'(i);
            CIN_LAST = (i == 9);
            tick();
        end
        CIN_VALID = 0;
        repeat (2) tick();
        check(16'(cq.size()), 16'h0003);
        for (int i = 0; i < 3; i++) check(16'(cq[i]), 16'({i == 2, 2'b01, 8'(8'hA0 + i)}));
        check(16'(pq.size()), 16'h000A);
        for (int i = 0; i < 10; i++) check(16'(pq[i]), 16'({i == 3 || i == 7 || i == 9, i != 9, 2'b10, 8'(i)}));
    endtask
    task automatic t_reset();
        c0 = cnt[0];
        c1 = cnt[1];
        pulse(PKT_RESET_REQ);
        wait_cnt(5, 1);
        check(16'(cnt[1] - c1), 16'h0001);
        check(16'(cnt[0] > c0), 16'h0001);
    endtask
    task automatic t_pktclear();
        c2 = cnt[2];
        pulse(PKT_CLEAR_REQ);
        wait_cnt(4, cnt[4] + 1);
        check(16'(cnt[2] - c2), 16'h0001);
        wait_ready(n);
        check(16'(n >= G - 2 && n <= G + 3), 16'h0001);
    endtask
    task automatic t_noans();
        ans = 0;
        c2 = cnt[2];
        c3 = cnt[3];
        pulse(PKT_CALL_REQ);
        wait_cnt(2, c2 + 1);
        tick();
        check(16'(cnt[3] - c3), 16'h0001);
        pulse(PKT_CLEAR_CONF);
        wait_ready(n);
        check(16'(READY_FOR_CALLS), 16'h0001);
        ans = 1;
    endtask
    task automatic t_cktclear();
        c2 = cnt[2];
        c3 = cnt[3];
        pulse(CKT_CLEAR_IND);
        wait_cnt(3, c3 + 1);
        check(16'(cnt[2] - c2), 16'h0001);
        repeat (6) tick();
        check(16'(READY_FOR_CALLS), 16'h0000);
        pulse(PKT_CLEAR_CONF);
        wait_ready(n);
        check(16'(READY_FOR_CALLS), 16'h0001);
    endtask
    task automatic t_local();
        c1 = cnt[1];
        c3 = cnt[3];
        DISC_BEFORE_CLEAR = 1;
        pulse(LOCAL_RELEASE);
        wait_cnt(3, c3 + 1);
        check(16'(cnt[1] - c1), 16'h0001);
        DISC_BEFORE_CLEAR = 0;
        pulse(PKT_CLEAR_CONF);
        wait_ready(n);
        check(16'(READY_FOR_CALLS), 16'h0001);
    endtask
    task automatic t_long();
        int c;
        c = cnt[7];
        for (int i = 0; i < 2049; i++) begin
            CIN_VALID = 1;
            CIN_DATA = 8'(i);
            CIN_LAST = (i == 2048);
            tick();
        end
        CIN_VALID = 0;
        CIN_LAST = 0;
        repeat (2) tick();
        check(16'(cnt[7] - c), 16'h0001);
    endtask
    task automatic t_restart();
        c1 = cnt[1];
        c3 = cnt[3];
        pulse(PKT_RESTART_REQ);
        wait_cnt(6, 1);
        check(16'(cnt[1] - c1), 16'h0001);
        check(16'(cnt[3] - c3), 16'h0000);
        wait_ready(n);
        check(16'(READY_FOR_CALLS), 16'h0001);
    endtask
    initial begin
        repeat (12) @(posedge CORE_CLK);
        #1 RST_B = 1;
        repeat (2) tick();
        check(16'(READY_FOR_CALLS), 16'h0001);
        t_noline();
        t_connect();
        t_data();
        t_reset();
        t_pktclear();
        t_noans();
        t_connect();
        t_cktclear();
        t_connect();
        t_local();
        t_connect();
        t_long();
        t_restart();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        failures++;
        end_of_test();
    end
endmodule
